// ==== design/psiar_pkg.sv ====
// holds constants for the transceiver status, identifier and advertisement slice
// assumes a word-addressed 32-bit register bus in front of the slice
package psiar_pkg;
	// ********************************************
	// bus geometry and register indices
	// ********************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam logic [11:0] IDX_STATUS = 12'h102;
	localparam logic [11:0] IDX_ID_HI = 12'h104;
	localparam logic [11:0] IDX_ID_LO = 12'h106;
	localparam logic [11:0] IDX_ADV = 12'h108;
	localparam logic [11:0] IDX_IRQ_STAT = 12'h120;
	localparam logic [11:0] IDX_IRQ_MASK = 12'h121;

	// ********************************************
	// link capability status layout
	// ********************************************
	localparam int ST_T4 = 15;
	localparam int ST_AN_DONE = 5;
	localparam int ST_RFAULT = 4;
	localparam int ST_LINK = 2;
	localparam int ST_JABBER = 1;
	// fixed ones: bits 14..11, 8, 6, 3 and 0; bit 15 and reserved bits zero
	localparam logic [15:0] STATUS_FIXED = 16'h7949;

	// ********************************************
	// advertisement layout and reset values
	// ********************************************
	localparam logic [15:0] ADV_WR_MASK = 16'hADFF;
	localparam logic ADV_RST_NEXT_PAGE = 1'b0;
	localparam logic ADV_RST_FAR_FAULT = 1'b0;
	localparam logic [3:0] ADV_RST_ABIL = 4'hF;
	localparam logic [4:0] ADV_RST_SEL = 5'h01;

	typedef enum logic [1:0] {
		PSIAR_PAUSE_NONE = 2'b00,
		PSIAR_PAUSE_SYM = 2'b01,
		PSIAR_PAUSE_ASYM_PARTNER = 2'b10,
		PSIAR_PAUSE_BOTH = 2'b11
	} psiar_pause_e;
	localparam psiar_pause_e PAUSE_STRAP_HI = PSIAR_PAUSE_BOTH;
	localparam psiar_pause_e PAUSE_STRAP_LO = PSIAR_PAUSE_NONE;

	// ********************************************
	// interrupt event bits
	// ********************************************
	localparam int EV_W = 4;
	localparam int EV_LINK_DOWN = 0;
	localparam int EV_RFAULT = 1;
	localparam int EV_JABBER = 2;
	localparam int EV_AN_DONE = 3;
	localparam logic [3:0] IRQ_MASK_RST = 4'h0;
endpackage

// ==== design/psiar_regs.sv ====
// holds the per-port status, identifier and advertisement registers behind Avalon-MM
// assumes condition inputs synchronous to clk and clk_en high during bus transfers
// Functional notes
// - status bit 15 always reads zero: no four-pair 100M mode
// - status bits 14..11 read one: 100M and 10M, full and half
// - status bit 8 reads one: extended status register present
// - preambleless frames accepted; status bit 6 reads one
// - status bit 5 follows negotiation complete
// - status bit 4 latches high on far-end fault until read
// - status bit 3 reads one: negotiation capable
// - status bit 1 latches high on jabber until read
// - status bit 0 reads one: extended register set supported
// - two read-only words return identifier high and low
// - advertisement bit 15 writable, resets zero: next page
// - advertisement bit 13 writable, resets zero: far-end fault
// - advertisement bits 11..10 writable pause encoding
// - pause field reset value comes from the configuration strap
// - advertisement bit 9 read-only zero
// - advertisement bits 8..5 writable, reset to ones
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
module psiar_regs #(
	parameter logic [15:0] ID_HIGH = 16'hA5C3, // arbitrary value
	parameter logic [15:0] ID_LOW = 16'h3C5A // arbitrary value
) (
	// clock and control
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// avalon-mm slave
	input wire logic [psiar_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [psiar_pkg::DATA_W-1:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [psiar_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	// conditions from the negotiation logic
	input wire logic an_complete,
	input wire logic remote_fault,
	input wire logic link_up,
	input wire logic jabber,
	input wire logic pause_default_strap,
	// interrupt
	output logic irq
);
	import psiar_pkg::*;

	// ********************************************
	// state
	// ********************************************
	logic rf_latch;
	logic jab_latch;
	logic link_latched_low;
	logic [REG_W-1:0] adv;
	logic [EV_W-1:0] irq_stat;
	logic [EV_W-1:0] irq_mask;
	logic link_prev;
	logic rf_prev;
	logic jab_prev;
	logic an_prev;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] next_irq_stat;
	logic [REG_W-1:0] status_word;
	logic [REG_W-1:0] wr_mask;
	logic req;
	logic rd_acc;
	logic wr_acc;
	logic rd_status;
	logic rd_irq;

	// ********************************************
	// bus handshake
	// ********************************************
	// one wait state: data is captured in the wait cycle, the access completes on the next edge
	assign req = read | write;
	assign rd_acc = clk_en & read & ~waitrequest;
	assign wr_acc = clk_en & write & ~waitrequest;
	assign rd_status = rd_acc & (address == IDX_STATUS);
	assign rd_irq = rd_acc & (address == IDX_IRQ_STAT);

	always_ff @(posedge clk) begin
		if (reset) begin
			waitrequest <= 1'b1;
		end else if (clk_en) begin
			waitrequest <= ~(req & waitrequest);
		end
	end

	function automatic logic [DATA_W-1:0] rd_word(input logic [ADDR_W-1:0] idx, input logic [REG_W-1:0] st,
		input logic [REG_W-1:0] ad, input logic [EV_W-1:0] is, input logic [EV_W-1:0] im);
		logic [DATA_W-1:0] w;
		w = '0;
		unique case (idx)
			IDX_STATUS: w[REG_W-1:0] = st;
			IDX_ID_HI: w[REG_W-1:0] = ID_HIGH;
			IDX_ID_LO: w[REG_W-1:0] = ID_LOW;
			IDX_ADV: w[REG_W-1:0] = ad;
			IDX_IRQ_STAT: w[EV_W-1:0] = is;
			IDX_IRQ_MASK: w[EV_W-1:0] = im;
			default: w = '0;
		endcase
		return w;
	endfunction

	// fixed capability bits come from one constant word
	always_comb begin
		status_word = STATUS_FIXED;
		status_word[ST_AN_DONE] = an_complete;
		status_word[ST_RFAULT] = rf_latch;
		status_word[ST_LINK] = link_latched_low;
		status_word[ST_JABBER] = jab_latch;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			readdata <= '0;
		end else if (clk_en && read && waitrequest) begin
			readdata <= rd_word(address, status_word, adv, irq_stat, irq_mask);
		end
	end

	// ********************************************
	// latched status bits
	// ********************************************
	// the clear on read only drops what was reported, so an event after the snapshot survives
	always_ff @(posedge clk) begin
		if (reset) begin
			rf_latch <= 1'b0;
		end else if (clk_en) begin
			if (rd_status) begin
				rf_latch <= remote_fault | (rf_latch & ~readdata[ST_RFAULT]);
			end else if (remote_fault) begin
				rf_latch <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			jab_latch <= 1'b0;
		end else if (clk_en) begin
			if (rd_status) begin
				jab_latch <= jabber | (jab_latch & ~readdata[ST_JABBER]);
			end else if (jabber) begin
				jab_latch <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			link_latched_low <= 1'b0;
		end else if (clk_en) begin
			if (rd_status) begin
				link_latched_low <= link_up & (link_latched_low | ~readdata[ST_LINK]);
			end else begin
				link_latched_low <= link_latched_low & link_up;
			end
		end
	end

	// ********************************************
	// advertisement register
	// ********************************************
	assign wr_mask = ADV_WR_MASK & {{8{byteenable[1]}}, {8{byteenable[0]}}};

	// sync reset is clocked, so catching the strap here is safe
	always_ff @(posedge clk) begin
		if (reset) begin
			adv <= '0;
			adv[15] <= ADV_RST_NEXT_PAGE;
			adv[13] <= ADV_RST_FAR_FAULT;
			adv[11:10] <= pause_default_strap ? PAUSE_STRAP_HI : PAUSE_STRAP_LO;
			adv[8:5] <= ADV_RST_ABIL;
			adv[4:0] <= ADV_RST_SEL;
		end else if (wr_acc && address == IDX_ADV) begin
			adv <= (adv & ~wr_mask) | (writedata[REG_W-1:0] & wr_mask);
		end
	end

	// ********************************************
	// interrupt
	// ********************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			link_prev <= 1'b0;
			rf_prev <= 1'b0;
			jab_prev <= 1'b0;
			an_prev <= 1'b0;
		end else if (clk_en) begin
			link_prev <= link_up;
			rf_prev <= remote_fault;
			jab_prev <= jabber;
			an_prev <= an_complete;
		end
	end

	always_comb begin
		ev = '0;
		ev[EV_LINK_DOWN] = link_prev & ~link_up;
		ev[EV_RFAULT] = remote_fault & ~rf_prev;
		ev[EV_JABBER] = jabber & ~jab_prev;
		ev[EV_AN_DONE] = an_complete & ~an_prev;
		next_irq_stat = ev | irq_stat;
		if (rd_irq) begin
			next_irq_stat = ev | (irq_stat & ~readdata[EV_W-1:0]);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			irq_stat <= '0;
		end else if (clk_en) begin
			irq_stat <= next_irq_stat;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			irq_mask <= IRQ_MASK_RST;
		end else if (wr_acc && address == IDX_IRQ_MASK && byteenable[0]) begin
			irq_mask <= writedata[EV_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(next_irq_stat & irq_mask);
		end
	end

	// ********************************************
	// assertions
	// ********************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_rd_done(logic [ADDR_W-1:0] idx);
		clk_en && read && !waitrequest && address == idx && $past(clk_en);
	endsequence

	sequence s_adv_write;
		clk_en && write && !waitrequest && address == IDX_ADV && byteenable[1:0] == 2'b11;
	endsequence

	AST_T4_ZERO: assert property (s_rd_done(IDX_STATUS) |-> !readdata[ST_T4])
		else $error("status bit 15 read as one");
	AST_ABIL_ONES: assert property (s_rd_done(IDX_STATUS) |-> readdata[14:11] == 4'hF)
		else $error("status ability bits not all one");
	AST_FIXED_ONES: assert property (
		s_rd_done(IDX_STATUS) |-> readdata[8] && readdata[6] && readdata[3] && readdata[0])
		else $error("fixed status one bits wrong");
	AST_AN_DONE: assert property (s_rd_done(IDX_STATUS) |-> readdata[ST_AN_DONE] == $past(an_complete))
		else $error("negotiation complete bit does not follow input");
	AST_RF_LATCH: assert property (clk_en && (remote_fault || rf_latch) && !rd_status |=> rf_latch)
		else $error("far-end fault not held until read");
	AST_LINK_LATCH_LOW: assert property (
		clk_en && !link_up |=> !link_latched_low ##1 (!link_latched_low || $past(rd_status)))
		else $error("link drop not latched low");
	AST_JAB_LATCH: assert property (clk_en && jabber |=> jab_latch)
		else $error("jabber not latched");
	AST_ID_WORDS: assert property (s_rd_done(IDX_ID_HI) |-> readdata == {16'h0000, ID_HIGH})
		else $error("identifier high word wrong");
	AST_ADV_RO: assert property (
		s_rd_done(IDX_ADV) |-> readdata[14] == 1'b0 && readdata[12] == 1'b0 && readdata[9] == 1'b0)
		else $error("read-only advertisement bits not zero");
	AST_ADV_WRITE: assert property (
		s_adv_write |=> adv == ($past(writedata[REG_W-1:0]) & ADV_WR_MASK))
		else $error("advertisement write not stored");
	AST_ADV_RESET: assert property (
		disable iff (1'b0) $past(reset) && !reset |-> adv[8:0] == 9'h1E1 && adv[15:12] == 4'h0)
		else $error("advertisement reset value wrong");
	AST_PAUSE_STRAP: assert property (
		disable iff (1'b0) $past(reset) && !reset |->
		adv[11:10] == ($past(pause_default_strap) ? PAUSE_STRAP_HI : PAUSE_STRAP_LO))
		else $error("pause default not taken from strap");
	AST_WAIT_ONE: assert property (clk_en && req && waitrequest |=> !waitrequest ##1 (waitrequest || !$past(clk_en)))
		else $error("bus answer not after one wait state");
	AST_IRQ_LEVEL: assert property (clk_en && |(next_irq_stat & irq_mask) |=> irq)
		else $error("interrupt not raised for unmasked event");

	// ********************************************
	// clearing, freeze and interrupt checks
	// ********************************************
	// a read drops a latched bit only once the snapshot showed it and the condition is gone
	sequence s_fault_reported;
		rd_status && readdata[ST_RFAULT] && !remote_fault;
	endsequence

	sequence s_jabber_reported;
		rd_status && readdata[ST_JABBER] && !jabber;
	endsequence

	sequence s_link_down_reported;
		rd_status && !readdata[ST_LINK] && link_up;
	endsequence

	sequence s_link_low_unread;
		clk_en && !link_latched_low && !rd_status;
	endsequence

	AST_RF_CLEAR: assert property (s_fault_reported |=> !rf_latch)
		else $error("far-end fault not cleared by status read");
	AST_JAB_CLEAR: assert property (s_jabber_reported |=> !jab_latch)
		else $error("jabber not cleared by status read");
	AST_LINK_BACK: assert property (s_link_down_reported |=> link_latched_low)
		else $error("link bit not restored by status read");
	AST_LINK_HOLD: assert property (s_link_low_unread |=> !link_latched_low)
		else $error("link bit rose without a status read");

	// lane 0 alone must leave the upper byte, pause and next-page bits included
	sequence s_adv_low_lane;
		clk_en && write && !waitrequest && address == IDX_ADV && byteenable[1:0] == 2'b01;
	endsequence

	sequence s_mask_write;
		clk_en && write && !waitrequest && address == IDX_IRQ_MASK && byteenable[0];
	endsequence

	AST_ADV_LANE: assert property (s_adv_low_lane |=> adv[15:8] == $past(adv[15:8]))
		else $error("advertisement upper byte changed by low lane write");
	AST_ADV_ZERO_BITS: assert property (!adv[14] && !adv[12] && !adv[9])
		else $error("read-only advertisement bit stored as one");
	AST_ADV_HOLD: assert property (!(wr_acc && address == IDX_ADV) |=> $stable(adv))
		else $error("advertisement changed without a write");
	AST_ID_LOW: assert property (s_rd_done(IDX_ID_LO) |-> readdata == {16'h0000, ID_LOW})
		else $error("identifier low word wrong");
	AST_UPPER_ZERO: assert property (readdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	AST_MASK_WRITE: assert property (s_mask_write |=> irq_mask == $past(writedata[EV_W-1:0]))
		else $error("interrupt mask write not stored");

	// clk_en low must leave every register as it was
	AST_FREEZE: assert property (!clk_en |=> $stable({adv, irq_stat, irq_mask, rf_latch, jab_latch, link_latched_low}))
		else $error("state changed while clock enable low");
	AST_FREEZE_BUS: assert property (!clk_en |=> $stable({waitrequest, readdata, irq}))
		else $error("bus or interrupt output changed while clock enable low");
	AST_IDLE_WAIT: assert property (clk_en && !req |=> waitrequest)
		else $error("waitrequest low without a request");
	AST_RDATA_STANDS: assert property (!(clk_en && read && waitrequest) |=> $stable(readdata))
		else $error("read data changed outside a capture");

	// each rising condition and each link drop sets its status bit on the next edge; a clearing read in that cycle loses
	sequence s_jabber_rise;
		clk_en && jabber && !jab_prev;
	endsequence

	sequence s_fault_rise;
		clk_en && remote_fault && !rf_prev;
	endsequence

	sequence s_link_fall;
		clk_en && link_prev && !link_up;
	endsequence

	sequence s_an_rise;
		clk_en && an_complete && !an_prev;
	endsequence

	sequence s_irq_read_quiet;
		rd_irq && ev == '0;
	endsequence

	AST_IRQ_JABBER: assert property (s_jabber_rise |=> irq_stat[EV_JABBER])
		else $error("jabber event not recorded");
	AST_IRQ_FAULT: assert property (s_fault_rise |=> irq_stat[EV_RFAULT])
		else $error("far-end fault event not recorded");
	AST_IRQ_LINK: assert property (s_link_fall |=> irq_stat[EV_LINK_DOWN])
		else $error("link drop event not recorded");
	AST_IRQ_AN: assert property (s_an_rise |=> irq_stat[EV_AN_DONE])
		else $error("negotiation complete event not recorded");
	AST_IRQ_CLEAR: assert property (s_irq_read_quiet |=> (irq_stat & $past(readdata[EV_W-1:0])) == '0)
		else $error("reported interrupt bits not cleared by read");
	AST_IRQ_QUIET: assert property ($past(clk_en) && $past(irq_mask) == '0 |-> !irq)
		else $error("interrupt raised with every source masked");
endmodule

// ==== sim/tb.sv ====
// holds the self-checking bench for the status, identifier and advertisement registers
// assumes psiar_pkg and psiar_regs are compiled first; the bench alone drives every input
`timescale 1ns/1ps
module tb;
	import psiar_pkg::*;
	localparam logic [15:0] TB_ID_HI = 16'h1357; // arbitrary value
	localparam logic [15:0] TB_ID_LO = 16'h2468; // arbitrary value
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic clk_en = 1'b1;
	logic [ADDR_W-1:0] address = '0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [DATA_W-1:0] writedata = '0;
	logic [3:0] byteenable = 4'h0;
	logic [DATA_W-1:0] readdata;
	logic waitrequest;
	logic an_complete = 1'b0;
	logic remote_fault = 1'b0;
	logic link_up = 1'b1;
	logic jabber = 1'b0;
	logic pause_default_strap = 1'b1;
	logic irq;
	int err_count = 0;
	int total_checks = 0;
	logic [31:0] rd;

	always #2 clk = ~clk;

	psiar_regs #(.ID_HIGH(TB_ID_HI), .ID_LOW(TB_ID_LO)) uut (.clk(clk), .reset(reset), .clk_en(clk_en),
		.address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .an_complete(an_complete),
		.remote_fault(remote_fault), .link_up(link_up), .jabber(jabber),
		.pause_default_strap(pause_default_strap), .irq(irq));

	// ********************************************
	// shared helpers
	// ********************************************
	task automatic conclude();
		if (err_count == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// request held until the edge that samples waitrequest low; read data taken at that edge
	task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk);
		read <= ~we;
		write <= we;
		address <= a;
		writedata <= wd;
		byteenable <= be;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 50) begin
			$display("BAD waitrequest expected 0 seen %b", waitrequest);
			err_count++;
		end
	endtask

	task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000, 4'h3);
		chk(what, exp, rd);
	endtask

	task automatic do_reset(input logic strap);
		pause_default_strap <= strap;
		reset <= 1'b1;
		tick(4);
		reset <= 1'b0;
	endtask

	// ********************************************
	// scenarios
	// ********************************************
	task automatic t_adv_default(input logic strap, input logic [31:0] exp);
		do_reset(strap);
		rchk("adv reset", IDX_ADV, exp);
	endtask

	// clock enable low freezes latches and edge detectors, so a pulse inside the gap is lost
	task automatic t_freeze();
		clk_en <= 1'b0;
		tick(1);
		jabber <= 1'b1;
		tick(3);
		jabber <= 1'b0;
		tick(2);
		clk_en <= 1'b1;
		tick(2);
		chk("irq frozen", 32'h0, {31'h0, irq});
		rchk("status frozen", IDX_STATUS, 32'h0000_794D);
		rchk("irq status frozen", IDX_IRQ_STAT, 32'h0000_0000);
	endtask

	task automatic t_status_live();
		rchk("status first", IDX_STATUS, 32'h0000_7949);
		an_complete <= 1'b1;
		tick(3);
		rchk("status an done", IDX_STATUS, 32'h0000_796D);
		an_complete <= 1'b0;
		tick(3);
		rchk("status an idle", IDX_STATUS, 32'h0000_794D);
	endtask

	task automatic t_latches();
		remote_fault <= 1'b1;
		tick(2);
		remote_fault <= 1'b0;
		tick(3);
		rchk("status fault held", IDX_STATUS, 32'h0000_795D);
		rchk("status fault gone", IDX_STATUS, 32'h0000_794D);
		jabber <= 1'b1;
		tick(2);
		jabber <= 1'b0;
		tick(3);
		rchk("status jabber held", IDX_STATUS, 32'h0000_794F);
		rchk("status jabber gone", IDX_STATUS, 32'h0000_794D);
		link_up <= 1'b0;
		tick(3);
		link_up <= 1'b1;
		tick(3);
		rchk("status link low held", IDX_STATUS, 32'h0000_7949);
		rchk("status link back", IDX_STATUS, 32'h0000_794D);
		chk("irq all masked", 32'h0, {31'h0, irq});
	endtask

	// all four events occurred above with the mask still at zero
	task automatic t_irq();
		rchk("irq mask reset", IDX_IRQ_MASK, 32'h0000_0000);
		rchk("irq status", IDX_IRQ_STAT, 32'h0000_000F);
		bus(1'b1, IDX_IRQ_MASK, 32'h0000_0004, 4'h1);
		tick(2);
		chk("irq idle", 32'h0, {31'h0, irq});
		jabber <= 1'b1;
		tick(4);
		chk("irq raised", 32'h1, {31'h0, irq});
		jabber <= 1'b0;
		remote_fault <= 1'b1;
		tick(2);
		remote_fault <= 1'b0;
		rchk("irq status pair", IDX_IRQ_STAT, 32'h0000_0006);
		tick(3);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rchk("status after irq", IDX_STATUS, 32'h0000_795F);
	endtask

	task automatic t_ids_unmapped();
		rchk("id high", IDX_ID_HI, {16'h0, TB_ID_HI});
		rchk("id low", IDX_ID_LO, {16'h0, TB_ID_LO});
		bus(1'b1, IDX_ID_HI, 32'h0000_FFFF, 4'h3);
		rchk("id high ro", IDX_ID_HI, {16'h0, TB_ID_HI});
		bus(1'b1, IDX_STATUS, 32'h0000_0000, 4'h3);
		rchk("status ro", IDX_STATUS, 32'h0000_794D);
		rchk("unmapped", 12'h1FF, 32'h0000_0000);
	endtask

	task automatic t_adv_rw();
		bus(1'b1, IDX_ADV, 32'hFFFF_FFFF, 4'h3);
		rchk("adv all ones", IDX_ADV, 32'h0000_ADFF);
		bus(1'b1, IDX_ADV, 32'h0000_0000, 4'h1);
		rchk("adv low lane", IDX_ADV, 32'h0000_AD00);
		bus(1'b1, IDX_ADV, 32'h0000_0000, 4'h3);
		rchk("adv all zero", IDX_ADV, 32'h0000_0000);
		for (int p = 0; p < 4; p++) begin
			bus(1'b1, IDX_ADV, {20'h0, p[1:0], 10'h000}, 4'h3);
			rchk("adv pause", IDX_ADV, {20'h0, p[1:0], 10'h000});
		end
	endtask

	// ********************************************
	// main sequence and watchdog
	// ********************************************
	initial begin
		t_adv_default(1'b1, 32'h0000_0DE1);
		t_status_live();
		t_latches();
		t_irq();
		t_ids_unmapped();
		t_freeze();
		t_adv_rw();
		t_adv_default(1'b0, 32'h0000_01E1);
		conclude();
	end

	// the whole run needs well under a thousand cycles
	initial begin
		tick(5000);
		err_count++;
		conclude();
	end
endmodule
